// >>> src/pssel_top.sv
// preset speed, jog and frequency source selector with wishbone registers
// Overview of operation
// - binary mode waits settle time after last select edge before taking index
// - binary index: select one is bit zero, select two bit one
// - four selects form index 0..15, select four msb, each own preset
// - unassigned select inputs count as off
// - mode field 00 selects binary mode
// - mode field 01 selects one-hot mode, seven inputs pick presets 1..7
// - active one-hot input n picks preset n from its stored value
// - several one-hot inputs on: lowest numbered wins
// - all selects off gives preset 0 from configured frequency source
// - monitor register shows the output frequency command and edits stored value of selected preset
// - second copy of preset 0 and source used under second-motor input
// - nonzero preset beats source; jog over force terminal over force operator
// - jog applies jog frequency with no ramp, min frequency to 10.00 Hz
// - active jog beats source, presets and both force overrides
// - stop mode 00..05: free/decel/dc, 00..02 disable, 03..05 enable at run
// - modes 00..02: run before jog never enters jog
// - modes 03..05 allow late jog; jog dropping first gives free-run stop
// - source 03 takes serial fieldbus command
// - source 04 takes option card command
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module pssel_top #(
  parameter int FW          = 16,
  parameter int STEP_CYCLES = pssel_pkg::STEP_CYCLES
) (
  // clock and reset
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst,
  // wishbone slave
  input  wire logic          i_wb_cyc,
  input  wire logic          i_wb_stb,
  input  wire logic          i_wb_we,
  input  wire logic [7:0]    i_wb_adr,
  input  wire logic [3:0]    i_wb_sel,
  input  wire logic [31:0]   i_wb_dat,
  output logic      [31:0]   o_wb_dat,
  output logic               o_wb_ack,
  // terminal inputs
  input  wire logic [6:0]    i_select_in,
  input  wire logic [6:0]    i_select_assigned,
  input  wire logic          i_jog_input,
  input  wire logic          i_run_cmd,
  input  wire logic          i_second_motor,
  input  wire logic          i_force_terminal_override,
  input  wire logic          i_force_operator_override,
  // frequency sources
  input  wire logic [FW-1:0] i_terminal_freq,
  input  wire logic [FW-1:0] i_operator_freq,
  input  wire logic [FW-1:0] i_analog_freq,
  input  wire logic [FW-1:0] i_serial_freq,
  input  wire logic [FW-1:0] i_option_freq,
  // command outputs
  output logic      [FW-1:0] o_freq_cmd,
  output logic               o_no_ramp,
  output logic      [3:0]    o_preset_index,
  output logic               o_stop_pulse,
  output logic      [1:0]    o_stop_kind
);
  // ****************************************
  // registers
  // ****************************************
  logic [31:0]   ctrl_reg, ctrl_next, ctrl2_reg, ctrl2_next;
  logic [FW-1:0] zero_reg, zero_next, zero2_reg, zero2_next;
  logic [FW-1:0] jog_reg, jog_next, minf_reg, minf_next;
  logic [FW-1:0] table_reg [16];
  logic [FW-1:0] table_next [16];
  logic          ack_reg, ack_next;
  logic [31:0]   rdat_reg, rdat_next;
  logic [1:0]    mode;
  logic [2:0]    stop_mode, src_sel;
  logic [7:0]    settle;
  logic          wr;
  logic [3:0]    idx_reg, idx_next;
  assign mode      = ctrl_reg[pssel_pkg::MODE_LSB +: 2];
  assign stop_mode = ctrl_reg[pssel_pkg::STOP_LSB +: 3];
  assign settle    = ctrl_reg[pssel_pkg::SETTLE_LSB +: 8];
  // second motor swaps in its own source select
  assign src_sel   = i_second_motor ? ctrl2_reg[pssel_pkg::SRC_LSB +: 3]
                                    : ctrl_reg[pssel_pkg::SRC_LSB +: 3];
  assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ~ack_reg;

  // byte-lane merge helper
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // register write decode; the monitor aliases onto the selected preset entry
  always_comb begin
    logic [31:0] m;
    m          = 32'h0000_0000;
    ctrl_next  = ctrl_reg;
    ctrl2_next = ctrl2_reg;
    zero_next  = zero_reg;
    zero2_next = zero2_reg;
    jog_next   = jog_reg;
    minf_next  = minf_reg;
    for (int k = 0; k < 16; k++) begin
      table_next[k] = table_reg[k];
    end
    if (wr) begin
      unique case (i_wb_adr)
        pssel_pkg::CTRL_OFF: begin
          m = merge(ctrl_reg, i_wb_dat, i_wb_sel);
          ctrl_next = m;
          // settle beyond 200 saturates so the range stays bounded
          if (m[pssel_pkg::SETTLE_LSB +: 8] > pssel_pkg::SETTLE_MAX) begin
            ctrl_next[pssel_pkg::SETTLE_LSB +: 8] = pssel_pkg::SETTLE_MAX;
          end
        end
        pssel_pkg::CTRL2_OFF: ctrl2_next = merge(ctrl2_reg, i_wb_dat, i_wb_sel);
        pssel_pkg::ZERO_OFF: begin
          m = merge({16'h0000, zero_reg}, i_wb_dat, i_wb_sel);
          zero_next = m[FW-1:0];
        end
        pssel_pkg::ZERO2_OFF: begin
          m = merge({16'h0000, zero2_reg}, i_wb_dat, i_wb_sel);
          zero2_next = m[FW-1:0];
        end
        pssel_pkg::JOG_OFF: begin
          m = merge({16'h0000, jog_reg}, i_wb_dat, i_wb_sel);
          jog_next = m[FW-1:0];
        end
        pssel_pkg::MINF_OFF: begin
          m = merge({16'h0000, minf_reg}, i_wb_dat, i_wb_sel);
          minf_next = m[FW-1:0];
        end
        pssel_pkg::MONITOR_OFF: begin
          m = merge({16'h0000, o_freq_cmd}, i_wb_dat, i_wb_sel);
          // preset 0 edits the copy in use for the active motor
          if (idx_reg == 4'h0) begin
            if (i_second_motor) begin
              zero2_next = m[FW-1:0];
            end else begin
              zero_next = m[FW-1:0];
            end
          end else begin
            table_next[idx_reg] = m[FW-1:0];
          end
        end
        default: begin
          if (i_wb_adr[7:6] == 2'h1) begin
            m = merge({16'h0000, table_reg[i_wb_adr[5:2]]}, i_wb_dat, i_wb_sel);
            table_next[i_wb_adr[5:2]] = m[FW-1:0];
          end
        end
      endcase
    end
  end

  // ****************************************
  // preset index decode and settle timer
  // ****************************************
  logic [6:0]  sel_eff, sel_prev_reg, sel_prev_next;
  logic [3:0]  raw_idx;
  logic [7:0]  steps_reg, steps_next;
  logic [31:0] cyc_reg, cyc_next;
  logic        pend_reg, pend_next;
  assign sel_eff = i_select_in & i_select_assigned;

  // raw index from current terminals
  always_comb begin
    raw_idx = 4'h0;
    if (mode == pssel_pkg::MODE_BINARY) begin
      raw_idx = sel_eff[3:0];
    end else if (mode == pssel_pkg::MODE_ONEHOT) begin
      // descending scan leaves the lowest active input in place
      for (int n = 6; n >= 0; n--) begin
        if (sel_eff[n]) begin
          raw_idx = 4'(n + 1);
        end
      end
    end
  end

  // settle timer only guards binary mode; one-hot follows directly
  always_comb begin
    sel_prev_next = sel_eff;
    steps_next    = steps_reg;
    cyc_next      = cyc_reg;
    pend_next     = pend_reg;
    idx_next      = idx_reg;
    if (mode != pssel_pkg::MODE_BINARY || settle == 8'h00) begin
      idx_next  = raw_idx;
      pend_next = 1'b0;
    end else if (sel_eff != sel_prev_reg) begin
      steps_next = settle;
      cyc_next   = 32'h0000_0000;
      pend_next  = 1'b1;
    end else if (pend_reg) begin
      if (steps_reg == 8'h00) begin
        idx_next  = raw_idx;
        pend_next = 1'b0;
      end else if (cyc_reg == 32'(STEP_CYCLES - 1)) begin
        cyc_next   = 32'h0000_0000;
        steps_next = steps_reg - 8'h01;
      end else begin
        cyc_next = cyc_reg + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // jog sequencer
  // ****************************************
  pssel_pkg::pssel_jog_t jst_reg, jst_next;
  logic       run_prev_reg;
  logic       stop_pulse_next;
  logic [1:0] stop_kind_reg, stop_kind_next, mode_kind;
  logic       late_ok;
  assign late_ok   = stop_mode >= pssel_pkg::STOP_ENABLE_MIN;
  // codes 0/3 free, 1/4 decel, 2/5 dc
  assign mode_kind = late_ok ? 2'(stop_mode - pssel_pkg::STOP_ENABLE_MIN)
                             : stop_mode[1:0];

  always_comb begin
    jst_next        = jst_reg;
    stop_pulse_next = 1'b0;
    stop_kind_next  = stop_kind_reg;
    unique case (jst_reg)
      pssel_pkg::JOG_IDLE: begin
        if (i_run_cmd && !run_prev_reg) begin
          // jog set up before run starts jog
          jst_next = i_jog_input ? pssel_pkg::JOG_RUN : pssel_pkg::JOG_NORM;
        end
      end
      pssel_pkg::JOG_NORM: begin
        if (!i_run_cmd) begin
          jst_next = pssel_pkg::JOG_IDLE;
        end else if (i_jog_input && late_ok) begin
          jst_next = pssel_pkg::JOG_RUN;
        end
      end
      pssel_pkg::JOG_RUN: begin
        if (!i_run_cmd) begin
          jst_next        = pssel_pkg::JOG_IDLE;
          stop_pulse_next = 1'b1;
          stop_kind_next  = mode_kind;
        end else if (!i_jog_input) begin
          // jog released first: coast and wait for run to drop
          jst_next        = pssel_pkg::JOG_HOLD;
          stop_pulse_next = 1'b1;
          stop_kind_next  = pssel_pkg::STOP_FREE;
        end
      end
      pssel_pkg::JOG_HOLD: begin
        if (!i_run_cmd) begin
          jst_next = pssel_pkg::JOG_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // frequency command selection
  // ****************************************
  logic [FW-1:0] src_freq, preset_freq, jog_clamped, freq_next;
  always_comb begin
    unique case (src_sel)
      pssel_pkg::SRC_PARAM:  src_freq = i_second_motor ? zero2_reg : zero_reg;
      pssel_pkg::SRC_SERIAL: src_freq = i_serial_freq;
      pssel_pkg::SRC_OPTION: src_freq = i_option_freq;
      default:               src_freq = i_analog_freq;
    endcase
    preset_freq = (idx_reg == 4'h0) ? src_freq : table_reg[idx_reg];
    jog_clamped = jog_reg;
    if (jog_reg > pssel_pkg::JOG_MAX) begin
      jog_clamped = pssel_pkg::JOG_MAX;
    end
    if (jog_clamped < minf_reg) begin
      jog_clamped = minf_reg;
    end
    // jog first, then force terminal, force operator, presets, source
    if (jst_reg == pssel_pkg::JOG_RUN) begin
      freq_next = jog_clamped;
    end else if (i_force_terminal_override) begin
      freq_next = i_terminal_freq;
    end else if (i_force_operator_override) begin
      freq_next = i_operator_freq;
    end else begin
      freq_next = preset_freq;
    end
  end

  // wishbone answer: one wait state, zero for unmapped reads
  always_comb begin
    ack_next  = i_wb_cyc & i_wb_stb & ~ack_reg;
    rdat_next = 32'h0000_0000;
    unique case (i_wb_adr)
      pssel_pkg::CTRL_OFF:    rdat_next = ctrl_reg;
      pssel_pkg::CTRL2_OFF:   rdat_next = ctrl2_reg;
      pssel_pkg::ZERO_OFF:    rdat_next = {16'h0000, zero_reg};
      pssel_pkg::ZERO2_OFF:   rdat_next = {16'h0000, zero2_reg};
      pssel_pkg::JOG_OFF:     rdat_next = {16'h0000, jog_reg};
      pssel_pkg::MINF_OFF:    rdat_next = {16'h0000, minf_reg};
      pssel_pkg::STATUS_OFF:  rdat_next = {24'h00_0000, jst_reg, stop_kind_reg, idx_reg};
      pssel_pkg::MONITOR_OFF: rdat_next = {16'h0000, o_freq_cmd};
      default: begin
        if (i_wb_adr[7:6] == 2'h1) begin
          rdat_next = {16'h0000, table_reg[i_wb_adr[5:2]]};
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_reg      <= pssel_pkg::CTRL_RST;
      ctrl2_reg     <= pssel_pkg::CTRL_RST;
      zero_reg      <= pssel_pkg::FREQ_RST;
      zero2_reg     <= pssel_pkg::FREQ_RST;
      jog_reg       <= pssel_pkg::FREQ_RST;
      minf_reg      <= pssel_pkg::FREQ_RST;
      ack_reg       <= 1'b0;
      rdat_reg      <= 32'h0000_0000;
      sel_prev_reg  <= 7'h00;
      steps_reg     <= 8'h00;
      cyc_reg       <= 32'h0000_0000;
      pend_reg      <= 1'b0;
      idx_reg       <= 4'h0;
      jst_reg       <= pssel_pkg::JOG_IDLE;
      run_prev_reg  <= 1'b0;
      stop_kind_reg <= pssel_pkg::STOP_FREE;
      o_stop_pulse  <= 1'b0;
      o_freq_cmd    <= pssel_pkg::FREQ_RST;
    end else begin
      ctrl_reg      <= ctrl_next;
      ctrl2_reg     <= ctrl2_next;
      zero_reg      <= zero_next;
      zero2_reg     <= zero2_next;
      jog_reg       <= jog_next;
      minf_reg      <= minf_next;
      ack_reg       <= ack_next;
      rdat_reg      <= rdat_next;
      sel_prev_reg  <= sel_prev_next;
      steps_reg     <= steps_next;
      cyc_reg       <= cyc_next;
      pend_reg      <= pend_next;
      idx_reg       <= idx_next;
      jst_reg       <= jst_next;
      run_prev_reg  <= i_run_cmd;
      stop_kind_reg <= stop_kind_next;
      o_stop_pulse  <= stop_pulse_next;
      o_freq_cmd    <= freq_next;
    end
  end

  // preset table, one entry per index
  for (genvar g = 0; g < 16; g++) begin : g_table
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        table_reg[g] <= pssel_pkg::FREQ_RST;
      end else begin
        table_reg[g] <= table_next[g];
      end
    end
  end

  assign o_wb_ack       = ack_reg;
  assign o_wb_dat       = rdat_reg;
  assign o_preset_index = idx_reg;
  assign o_stop_kind    = stop_kind_reg;
  assign o_no_ramp      = (jst_reg == pssel_pkg::JOG_RUN);

  // ****************************************
  // assertions
  // ****************************************
  settle_cap_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    settle <= pssel_pkg::SETTLE_MAX) else $error("settle above 200");
  zero_settle_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (mode == pssel_pkg::MODE_BINARY && settle == 8'h00 && $stable(settle))
      |=> idx_reg == $past(raw_idx)) else $error("zero settle not immediate");
  settle_hold_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (mode == pssel_pkg::MODE_BINARY && settle != 8'h00 && sel_eff != sel_prev_reg)
      |=> $stable(idx_reg)) else $error("index moved during settle");
  unassigned_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_select_assigned[3:0] != 4'hF && mode == pssel_pkg::MODE_BINARY)
      |-> (raw_idx & ~i_select_assigned[3:0]) == 4'h0)
    else $error("unassigned input counted");
  onehot_low_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    mode == pssel_pkg::MODE_ONEHOT && sel_eff[0] |-> raw_idx == 4'h1)
    else $error("lowest one-hot input lost");
  jog_first_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (jst_reg == pssel_pkg::JOG_IDLE && i_run_cmd && !run_prev_reg && i_jog_input)
      |=> o_no_ramp ##1 (o_freq_cmd == $past(jog_clamped) || !o_no_ramp))
    else $error("jog not started");
  late_block_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (jst_reg == pssel_pkg::JOG_NORM && !late_ok) |=> jst_reg != pssel_pkg::JOG_RUN)
    else $error("late jog entered while disabled");
  free_stop_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (jst_reg == pssel_pkg::JOG_RUN && i_run_cmd && !i_jog_input)
      |=> o_stop_pulse && o_stop_kind == pssel_pkg::STOP_FREE)
    else $error("jog release did not coast");
  force_rank_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (jst_reg != pssel_pkg::JOG_RUN && i_force_terminal_override)
      |=> o_freq_cmd == $past(i_terminal_freq)) else $error("force terminal lost");
  serial_src_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (jst_reg != pssel_pkg::JOG_RUN && !i_force_terminal_override && !i_force_operator_override
     && idx_reg == 4'h0 && src_sel == pssel_pkg::SRC_SERIAL)
      |=> o_freq_cmd == $past(i_serial_freq)) else $error("serial source lost");
endmodule : pssel_top
`default_nettype wire

// >>> shared/pssel_pkg.sv
// constants for the preset speed and jog selector
package pssel_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] CTRL2_OFF   = 8'h04;
  localparam logic [7:0] ZERO_OFF    = 8'h08;
  localparam logic [7:0] ZERO2_OFF   = 8'h0C;
  localparam logic [7:0] JOG_OFF     = 8'h10;
  localparam logic [7:0] MINF_OFF    = 8'h14;
  localparam logic [7:0] STATUS_OFF  = 8'h18;
  localparam logic [7:0] MONITOR_OFF = 8'h1C;
  localparam logic [7:0] TABLE_OFF   = 8'h40;
  // ****************************************
  // field positions in control words
  // ****************************************
  localparam int MODE_LSB   = 0;
  localparam int STOP_LSB   = 4;
  localparam int SRC_LSB    = 8;
  localparam int SETTLE_LSB = 16;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [15:0] FREQ_RST  = 16'h0000;
  localparam logic [7:0]  SETTLE_MAX = 8'hC8; // 200 steps of 10 ms
  // ****************************************
  // codes
  // ****************************************
  localparam logic [1:0] MODE_BINARY = 2'h0;
  localparam logic [1:0] MODE_ONEHOT = 2'h1;
  localparam logic [2:0] SRC_PARAM   = 3'h2;
  localparam logic [2:0] SRC_SERIAL  = 3'h3;
  localparam logic [2:0] SRC_OPTION  = 3'h4;
  localparam logic [2:0] STOP_ENABLE_MIN = 3'h3;
  localparam logic [1:0] STOP_FREE   = 2'h0;
  localparam logic [1:0] STOP_DECEL  = 2'h1;
  localparam logic [1:0] STOP_DC     = 2'h2;
  localparam logic [15:0] JOG_MAX    = 16'h03E8; // 10.00 Hz in 0.01 Hz
  // ****************************************
  // timing
  // ****************************************
  localparam int SETTLE_STEP_MS = 10;
  localparam int CLK_HZ         = 125_000_000;
  localparam int STEP_CYCLES    = CLK_HZ / 1000 * SETTLE_STEP_MS;
  // jog sequencer states
  typedef enum logic [1:0] {
    JOG_IDLE = 2'b00,
    JOG_NORM = 2'b01,
    JOG_RUN  = 2'b10,
    JOG_HOLD = 2'b11
  } pssel_jog_t;
endpackage : pssel_pkg

// >>> verification/pssel_terminals.sv
// model of the select, jog and run terminals that feed the selector
`timescale 1ns/1ns
`default_nettype none
module pssel_terminals (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // levels asked for by the bench
  input  wire logic [6:0] i_sel_req,
  input  wire logic       i_jog_req,
  input  wire logic       i_run_req,
  // terminal levels
  output logic      [6:0] o_select_in,
  output logic            o_jog_input,
  output logic            o_run_cmd
);
  // ****************************************
  // terminal drivers
  // ****************************************
  logic [8:0] state_next;
  // run waits a cycle when asked together with jog, so jog always leads
  always_comb begin
    state_next = {i_sel_req, i_jog_req,
                  i_run_req & (o_run_cmd | o_jog_input | ~i_jog_req)};
  end
  // terminals change only on the clock edge
  always_ff @(posedge i_sys_clk) begin
    {o_select_in, o_jog_input, o_run_cmd} <= i_rst ? 9'h000 : state_next;
  end
endmodule : pssel_terminals
`default_nettype wire

// >>> verification/preset_speed_jog_selector_bench.sv
// self-checking bench for the preset speed and jog selector
`timescale 1ns/1ns
`default_nettype none
module preset_speed_jog_selector_bench;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, q;
  logic [6:0]  sel_req = 7'h00, asg = 7'h7F, sel_in, v;
  logic        jog_req = 1'b0, run_req = 1'b0, jog_in, run_in, no_ramp, stp;
  logic        motor2 = 1'b0, f_tm = 1'b0, f_op = 1'b0;
  logic [15:0] tm_f, op_f, an_f, ser_f, opt_f, z0, z1, freq;
  logic [15:0] tbl [1:15];
  logic [3:0]  idx;
  logic [1:0]  kind, last_kind;
  int          seed = 36219, fails = 0, n_compared = 0, n_stop = 0, k;
  // ****************************************
  // clock, design and terminals
  // ****************************************
  always #4 clk = ~clk;
  pssel_top #(.STEP_CYCLES(10)) i_pssel_top (.i_sys_clk(clk), .i_rst(rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(rd), .o_wb_ack(ack), .i_select_in(sel_in),
    .i_select_assigned(asg), .i_jog_input(jog_in), .i_run_cmd(run_in),
    .i_second_motor(motor2), .i_force_terminal_override(f_tm),
    .i_force_operator_override(f_op), .i_terminal_freq(tm_f), .i_operator_freq(op_f),
    .i_analog_freq(an_f), .i_serial_freq(ser_f), .i_option_freq(opt_f),
    .o_freq_cmd(freq), .o_no_ramp(no_ramp), .o_preset_index(idx),
    .o_stop_pulse(stp), .o_stop_kind(kind));
  pssel_terminals i_pssel_terminals (.i_sys_clk(clk), .i_rst(rst), .i_sel_req(sel_req),
    .i_jog_req(jog_req), .i_run_req(run_req), .o_select_in(sel_in),
    .o_jog_input(jog_in), .o_run_cmd(run_in));
  // the stop pulse lasts one cycle, so count it here
  always @(posedge clk) begin
    if (stp === 1'b1) begin
      n_stop++;
      last_kind = kind;
    end
  end
  function automatic logic [15:0] rnd16();
    int r;
    r = $random(seed);
    return r[15:0];
  endfunction : rnd16
  function automatic logic [31:0] cw(int md, int st, int sr, int stl);
    return 32'(md) | 32'(st) << pssel_pkg::STOP_LSB | 32'(sr) << pssel_pkg::SRC_LSB
      | 32'(stl) << pssel_pkg::SETTLE_LSB;
  endfunction : cw
  // lowest input that is on wins; none on falls back to preset zero
  function automatic logic [15:0] oh_exp(input logic [6:0] s);
    for (int n = 0; n < 7; n++) if (s[n]) return tbl[n + 1];
    return z0;
  endfunction : oh_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cf(input logic [15:0] e);
    repeat (5) @(posedge clk);
    chk(freq, e);
  endtask : cf
  // classic cycle: hold everything until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n = 0;
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    r = rd;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask : wb
  task automatic results();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    results();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {tm_f, op_f, an_f, ser_f, opt_f, z0, z1} = 112'({$random(seed), $random(seed),
      $random(seed), $random(seed)});
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, pssel_pkg::CTRL_OFF, 0, q);
    chk(q, pssel_pkg::CTRL_RST);
    wb(1'b1, 8'hA0, 32'hFFFF, q);
    wb(1'b0, 8'hA0, 0, q);
    chk(q, 0);
    wb(1'b1, pssel_pkg::ZERO_OFF, {16'h0, z0}, q);
    wb(1'b1, pssel_pkg::ZERO2_OFF, {16'h0, z1}, q);
    wb(1'b1, pssel_pkg::CTRL2_OFF, cw(0, 0, 2, 0), q);
    for (int s = 1; s < 5; s++) begin
      wb(1'b1, pssel_pkg::CTRL_OFF, cw(0, 0, s, 0), q);
      cf(s == 1 ? an_f : s == 2 ? z0 : s == 3 ? ser_f : opt_f);
    end
    motor2 <= 1'b1;
    cf(z1);
    motor2 <= 1'b0;
    for (int n = 1; n < 16; n++) begin
      tbl[n] = rnd16();
      wb(1'b1, 8'(pssel_pkg::TABLE_OFF + 4 * n), {16'h0, tbl[n]}, q);
    end
    wb(1'b1, pssel_pkg::CTRL_OFF, cw(0, 0, 2, 0), q);
    for (int n = 0; n < 16; n++) begin
      sel_req <= 7'(n);
      cf(n == 0 ? z0 : tbl[n]);
      chk(idx, n);
    end
    asg <= 7'h7D;
    sel_req <= 7'h0F;
    cf(tbl[13]);
    asg <= 7'h7F;
    sel_req <= 7'h00;
    cf(z0);
    // settle beyond the top of its range must read back saturated
    wb(1'b1, pssel_pkg::CTRL_OFF, cw(0, 0, 2, 255), q);
    wb(1'b0, pssel_pkg::CTRL_OFF, 0, q);
    chk(q, cw(0, 0, 2, 200));
    wb(1'b1, pssel_pkg::CTRL_OFF, cw(0, 0, 2, 2), q);
    sel_req <= 7'h01;
    repeat (15) @(posedge clk);
    sel_req <= 7'h02;
    repeat (12) @(posedge clk);
    chk(idx, 0);
    repeat (14) @(posedge clk);
    chk(idx, 2);
    // an undefined mode code falls back to preset zero
    wb(1'b1, pssel_pkg::CTRL_OFF, cw(2, 0, 2, 0), q);
    cf(z0);
    chk(idx, 0);
    wb(1'b1, pssel_pkg::CTRL_OFF, cw(1, 0, 2, 0), q);
    for (int n = 0; n < 12; n++) begin
      v = n < 2 ? 7'(n * 127) : 7'(rnd16());
      sel_req <= v;
      cf(oh_exp(v));
    end
    sel_req <= 7'h04;
    cf(tbl[3]);
    wb(1'b1, pssel_pkg::MONITOR_OFF, 32'h1234, q);
    wb(1'b0, 8'(pssel_pkg::TABLE_OFF + 12), 0, q);
    chk(q, 32'h1234);
    f_op <= 1'b1;
    cf(op_f);
    f_tm <= 1'b1;
    cf(tm_f);
    wb(1'b1, pssel_pkg::JOG_OFF, 32'h0FFF, q);
    for (int m = 0; m < 6; m++) begin
      wb(1'b1, pssel_pkg::CTRL_OFF, cw(1, m, 2, 0), q);
      k = n_stop;
      {jog_req, run_req} <= 2'b11;
      cf(pssel_pkg::JOG_MAX);
      chk(no_ramp, 1);
      run_req <= 1'b0;
      repeat (2) @(posedge clk);
      jog_req <= 1'b0;
      repeat (4) @(posedge clk);
      chk(n_stop - k, 1);
      chk(last_kind, m % 3);
      run_req <= 1'b1;
      repeat (4) @(posedge clk);
      jog_req <= 1'b1;
      repeat (5) @(posedge clk);
      chk(no_ramp, m > 2);
      k = n_stop;
      jog_req <= 1'b0;
      repeat (4) @(posedge clk);
      run_req <= 1'b0;
      repeat (4) @(posedge clk);
      chk(n_stop - k, m > 2);
      chk(last_kind, m > 2 ? 0 : m % 3);
    end
    results();
  end
endmodule : preset_speed_jog_selector_bench
`default_nettype wire
